// ---- rtl/csb_pkg.sv ----
// ****************************************************************
// constants and types
// ****************************************************************
package csb_pkg;

   localparam int CSB_PC_W = 16;
   localparam logic [15:0] CSB_PC_RST = 16'h0000;
   localparam logic [7:0] CSB_STATUS_REGISTER_RST = 8'h00;
   localparam logic [7:0] CSB_REG_RST = 8'h00;
   localparam int CSB_NUM_REGS = 32;

   // status register bit positions
   localparam int CSB_FLAG_C = 0;
   localparam int CSB_FLAG_Z = 1;
   localparam int CSB_FLAG_N = 2;
   localparam int CSB_FLAG_V = 3;
   localparam int CSB_FLAG_S = 4;
   localparam int CSB_FLAG_H = 5;
   localparam int CSB_FLAG_T = 6;
   localparam int CSB_FLAG_I = 7;

   // first pointer pair, low and high byte
   localparam logic [4:0] CSB_PTR_LO = 5'h1a;
   localparam logic [4:0] CSB_PTR_HI = 5'h1b;

   // cycle counts
   localparam logic [1:0] CSB_CYC_ONE = 2'h1;
   localparam logic [1:0] CSB_CYC_BR_TAKEN = 2'h2;
   localparam logic [1:0] CSB_CYC_SKIP_ONE = 2'h2;
   localparam logic [1:0] CSB_CYC_SKIP_TWO = 2'h3;
   localparam logic [1:0] CSB_CYC_LOAD = 2'h2;

   // program counter and pointer steps
   localparam logic [15:0] CSB_PC_STEP = 16'h0001;
   localparam logic [15:0] CSB_PC_SKIP_ONE = 16'h0002;
   localparam logic [15:0] CSB_PC_SKIP_TWO = 16'h0003;
   localparam logic [15:0] CSB_PTR_STEP = 16'h0001;

   typedef enum logic [5:0] {
      compare_skip_equal = 6'h00,
      compare_regs = 6'h01,
      compare_regs_with_borrow = 6'h02,
      compare_immediate = 6'h03,
      skip_reg_bit_clear = 6'h04,
      skip_reg_bit_set = 6'h05,
      skip_io_bit_clear = 6'h06,
      skip_io_bit_set = 6'h07,
      branch_flag_set = 6'h08,
      branch_flag_clear = 6'h09,
      branch_equal = 6'h0a,
      branch_not_equal = 6'h0b,
      branch_carry_set = 6'h0c,
      branch_carry_clear = 6'h0d,
      branch_same_or_higher = 6'h0e,
      branch_lower = 6'h0f,
      branch_minus = 6'h10,
      branch_plus = 6'h11,
      branch_signed_ge = 6'h12,
      branch_signed_less = 6'h13,
      branch_halfcarry_set = 6'h14,
      branch_halfcarry_clear = 6'h15,
      branch_bitstore_set = 6'h16,
      branch_bitstore_clear = 6'h17,
      branch_overflow_set = 6'h18,
      branch_overflow_clear = 6'h19,
      branch_irq_enabled = 6'h1a,
      branch_irq_disabled = 6'h1b,
      load_indirect = 6'h1c,
      load_indirect_post_inc = 6'h1d
   } csb_op_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUSY = 3'b010,
      ST_LOAD = 3'b100
   } csb_state_e;

   typedef struct packed {
      csb_op_e op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [7:0] io_val;
      logic [6:0] offset;
      logic next_two_word;
   } csb_req_s;

   typedef struct packed {
      logic done;
      logic branched;
      logic skipped;
      logic [1:0] cycles;
   } csb_res_s;

endpackage : csb_pkg

// ---- rtl/csb_exec.sv ----
// Function
// (RULE_01) equal compare skips next instruction, 1-3 cycles
// (RULE_02) compares set Z N V C H, no writeback
// (RULE_03) register bit test skips on clear/set
// (RULE_04) io bit test skips on clear/set
// (RULE_05) generic flag branch to pc+k+1
// (RULE_06) zero flag selects equality branches
// (RULE_07) carry flag selects carry branches
// (RULE_08) negative flag selects sign branches
// (RULE_09) n xor v selects signed branches
// (RULE_10) half-carry flag selects half-carry branches
// (RULE_11) bit-copy flag selects transfer-bit branches
// (RULE_12) overflow flag selects overflow branches
// (RULE_13) interrupt enable selects interrupt branches
// (RULE_14) pointer load two cycles, optional post-increment
// (RULE_15) branch false one cycle, true two
// (RULE_16) skip costs 1, 2 or 3 cycles
// (RULE_17) offset is signed word count
`timescale 1ns/1ps
`default_nettype none
module csb_exec
   import csb_pkg::*;
(
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic req_valid_i,
   input wire csb_req_s req_i,
   output logic req_ready_o,
   input wire logic reg_wr_en_i,
   input wire logic [4:0] reg_wr_addr_i,
   input wire logic [7:0] reg_wr_data_i,
   input wire logic [4:0] reg_rd_addr_i,
   output logic [7:0] reg_rd_data_o,
   input wire logic status_register_wr_en_i,
   input wire logic [7:0] status_register_wr_data_i,
   output logic [7:0] status_o,
   output logic [15:0] pc_o,
   output logic mem_rd_o,
   output logic [15:0] mem_addr_o,
   input wire logic [7:0] mem_rdata_i,
   output csb_res_s res_o
);

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0] regs_reg [CSB_NUM_REGS];
   logic [7:0] status_register_reg;
   logic [15:0] pc_reg;
   csb_state_e state_reg;
   csb_state_e state_next;
   logic [1:0] cnt_reg;
   logic ready_reg;
   logic mem_rd_reg;
   logic [15:0] mem_addr_reg;
   logic [4:0] ld_rd_reg;
   logic ld_inc_reg;
   csb_res_s res_reg;
   logic [7:0] rd_data_reg;

   // ****************************************************************
   // operand and condition evaluation
   // ****************************************************************
   logic accept;
   logic [7:0] op_a;
   logic [7:0] op_b;
   logic [7:0] op_r;
   logic cin;
   logic [8:0] diff;
   logic [4:0] half;
   logic is_cmp;
   logic is_branch;
   logic is_skip;
   logic is_load;
   logic cond;
   logic [1:0] cyc;
   logic [15:0] pc_new;
   logic [15:0] offset_ext;
   logic [15:0] ptr;

   assign accept = req_valid_i & ready_reg & (state_reg == ST_IDLE);
   assign op_a = regs_reg[req_i.rd];
   assign op_r = regs_reg[req_i.rr];
   assign op_b = (req_i.op == compare_immediate) ? req_i.imm : op_r;
   assign cin = (req_i.op == compare_regs_with_borrow) ? status_register_reg[CSB_FLAG_C] : 1'b0;
   assign diff = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
   assign half = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
   assign offset_ext = {{9{req_i.offset[6]}}, req_i.offset}; // RULE_17
   assign ptr = {regs_reg[CSB_PTR_HI], regs_reg[CSB_PTR_LO]};

   always_comb begin
      is_cmp = 1'b0;
      is_branch = 1'b0;
      is_skip = 1'b0;
      is_load = 1'b0;
      cond = 1'b0;
      case (req_i.op)
         compare_skip_equal: begin
            is_skip = 1'b1;
            cond = (op_a == op_r); // RULE_01
         end
         compare_regs, compare_regs_with_borrow, compare_immediate: begin
            is_cmp = 1'b1; // RULE_02
         end
         skip_reg_bit_clear: begin
            is_skip = 1'b1;
            cond = ~op_r[req_i.bit_sel]; // RULE_03
         end
         skip_reg_bit_set: begin
            is_skip = 1'b1;
            cond = op_r[req_i.bit_sel]; // RULE_03
         end
         skip_io_bit_clear: begin
            is_skip = 1'b1;
            cond = ~req_i.io_val[req_i.bit_sel]; // RULE_04
         end
         skip_io_bit_set: begin
            is_skip = 1'b1;
            cond = req_i.io_val[req_i.bit_sel]; // RULE_04
         end
         branch_flag_set: begin
            is_branch = 1'b1;
            cond = status_register_reg[req_i.bit_sel]; // RULE_05
         end
         branch_flag_clear: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[req_i.bit_sel]; // RULE_05
         end
         branch_equal: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_Z]; // RULE_06
         end
         branch_not_equal: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[CSB_FLAG_Z]; // RULE_06
         end
         branch_carry_set, branch_lower: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_C]; // RULE_07
         end
         branch_carry_clear, branch_same_or_higher: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[CSB_FLAG_C]; // RULE_07
         end
         branch_minus: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_N]; // RULE_08
         end
         branch_plus: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[CSB_FLAG_N]; // RULE_08
         end
         branch_signed_ge: begin
            is_branch = 1'b1;
            cond = ~(status_register_reg[CSB_FLAG_N] ^ status_register_reg[CSB_FLAG_V]); // RULE_09
         end
         branch_signed_less: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_N] ^ status_register_reg[CSB_FLAG_V]; // RULE_09
         end
         branch_halfcarry_set: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_H]; // RULE_10
         end
         branch_halfcarry_clear: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[CSB_FLAG_H]; // RULE_10
         end
         branch_bitstore_set: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_T]; // RULE_11
         end
         branch_bitstore_clear: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[CSB_FLAG_T]; // RULE_11
         end
         branch_overflow_set: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_V]; // RULE_12
         end
         branch_overflow_clear: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[CSB_FLAG_V]; // RULE_12
         end
         branch_irq_enabled: begin
            is_branch = 1'b1;
            cond = status_register_reg[CSB_FLAG_I]; // RULE_13
         end
         branch_irq_disabled: begin
            is_branch = 1'b1;
            cond = ~status_register_reg[CSB_FLAG_I]; // RULE_13
         end
         load_indirect, load_indirect_post_inc: begin
            is_load = 1'b1;
         end
         default: begin
            cond = 1'b0;
         end
      endcase
   end

   always_comb begin
      pc_new = pc_reg + CSB_PC_STEP;
      cyc = CSB_CYC_ONE;
      if (is_branch && cond) begin
         pc_new = pc_reg + CSB_PC_STEP + offset_ext; // RULE_05
         cyc = CSB_CYC_BR_TAKEN; // RULE_15
      end else if (is_skip && cond) begin
         pc_new = pc_reg + (req_i.next_two_word ? CSB_PC_SKIP_TWO : CSB_PC_SKIP_ONE); // RULE_16
         cyc = req_i.next_two_word ? CSB_CYC_SKIP_TWO : CSB_CYC_SKIP_ONE; // RULE_16
      end else if (is_load) begin
         cyc = CSB_CYC_LOAD; // RULE_14
      end
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accept && is_load) begin
               state_next = ST_LOAD;
            end else if (accept && (cyc != CSB_CYC_ONE)) begin
               state_next = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (cnt_reg == CSB_CYC_ONE) begin
               state_next = ST_IDLE;
            end
         end
         ST_LOAD: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ST_IDLE;
         ready_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         ready_reg <= (state_next == ST_IDLE);
         if (accept) begin
            cnt_reg <= cyc - CSB_CYC_ONE; // RULE_15
         end else if (state_reg == ST_BUSY) begin
            cnt_reg <= cnt_reg - CSB_CYC_ONE;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         res_reg <= '0;
      end else begin
         res_reg.done <= (accept && (cyc == CSB_CYC_ONE)) || (state_reg == ST_LOAD)
                         || ((state_reg == ST_BUSY) && (cnt_reg == CSB_CYC_ONE));
         if (accept) begin
            res_reg.branched <= is_branch & cond;
            res_reg.skipped <= is_skip & cond;
            res_reg.cycles <= cyc;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc_reg <= CSB_PC_RST;
      end else if (accept) begin
         pc_reg <= pc_new;
      end
   end

   // ****************************************************************
   // status register
   // ****************************************************************
   // the s flag is left alone, compares only touch z n v c h
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status_register_reg <= CSB_STATUS_REGISTER_RST;
      end else if (accept && is_cmp) begin
         status_register_reg[CSB_FLAG_C] <= diff[8]; // RULE_02
         status_register_reg[CSB_FLAG_H] <= half[4]; // RULE_02
         status_register_reg[CSB_FLAG_N] <= diff[7]; // RULE_02
         status_register_reg[CSB_FLAG_V] <= (op_a[7] & ~op_b[7] & ~diff[7]) | (~op_a[7] & op_b[7] & diff[7]); // RULE_02
         // with borrow, zero is only kept so multi-byte compares chain
         if (req_i.op == compare_regs_with_borrow) begin
            status_register_reg[CSB_FLAG_Z] <= status_register_reg[CSB_FLAG_Z] & (diff[7:0] == 8'h00); // RULE_02
         end else begin
            status_register_reg[CSB_FLAG_Z] <= (diff[7:0] == 8'h00); // RULE_02
         end
      end else if (status_register_wr_en_i) begin
         status_register_reg <= status_register_wr_data_i;
      end
   end

   // ****************************************************************
   // indirect load
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mem_rd_reg <= 1'b0;
         mem_addr_reg <= 16'h0000;
         ld_rd_reg <= 5'h00;
         ld_inc_reg <= 1'b0;
      end else begin
         mem_rd_reg <= accept & is_load; // RULE_14
         if (accept && is_load) begin
            mem_addr_reg <= ptr;
            ld_rd_reg <= req_i.rd;
            ld_inc_reg <= (req_i.op == load_indirect_post_inc);
         end
      end
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   // the load writeback wins over the external write port; a post
   // increment wins over loading into the pointer itself
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < CSB_NUM_REGS; i++) begin
            regs_reg[i] <= CSB_REG_RST;
         end
      end else if (state_reg == ST_LOAD) begin
         regs_reg[ld_rd_reg] <= mem_rdata_i; // RULE_14
         if (ld_inc_reg) begin
            {regs_reg[CSB_PTR_HI], regs_reg[CSB_PTR_LO]} <= mem_addr_reg + CSB_PTR_STEP; // RULE_14
         end
      end else if (reg_wr_en_i) begin
         regs_reg[reg_wr_addr_i] <= reg_wr_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_reg <= 8'h00;
      end else begin
         rd_data_reg <= regs_reg[reg_rd_addr_i];
      end
   end

   assign req_ready_o = ready_reg;
   assign reg_rd_data_o = rd_data_reg;
   assign status_o = status_register_reg;
   assign pc_o = pc_reg;
   assign mem_rd_o = mem_rd_reg;
   assign mem_addr_o = mem_addr_reg;
   assign res_o = res_reg;

endmodule : csb_exec
`default_nettype wire

// ---- verif/csb_exec_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module csb_exec_sva
   import csb_pkg::*;
(
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic req_valid_i,
   input wire csb_req_s req_i,
   input wire logic req_ready_o,
   input wire logic [7:0] status_o,
   input wire logic [15:0] pc_o,
   input wire logic mem_rd_o,
   input wire csb_res_s res_o
);
   // ****************************************
   // helper state
   // ****************************************
   logic acc;
   logic is_br;
   logic is_ld;
   logic is_cmp;
   logic [15:0] tgt_reg;
   logic [15:0] seq_reg;
   assign acc = req_valid_i && req_ready_o;
   assign is_br = (req_i.op >= branch_flag_set) && (req_i.op <= branch_irq_disabled);
   assign is_ld = req_i.op inside {load_indirect, load_indirect_post_inc};
   assign is_cmp = req_i.op inside {compare_regs, compare_regs_with_borrow, compare_immediate};
   // targets captured at the taking edge, since pc_o itself moves on that edge
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tgt_reg <= 16'h0000;
         seq_reg <= 16'h0000;
      end else if (acc) begin
         tgt_reg <= pc_o + 16'h0001 + {{9{req_i.offset[6]}}, req_i.offset};
         seq_reg <= pc_o + 16'h0001;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);
   AST_DONE_READY: assert property (res_o.done |-> req_ready_o)
      else $error("done seen while not ready");
   AST_BR_CYC: assert property (res_o.done && res_o.branched |-> res_o.cycles == 2'h2 && !$past(req_ready_o))
      else $error("taken branch not two cycles");
   AST_BR_TGT: assert property (res_o.done && res_o.branched |-> pc_o == tgt_reg)
      else $error("branch target wrong");
   AST_BR_SEQ: assert property (acc && is_br |=> (res_o.done && !res_o.branched && pc_o == seq_reg)
      or (!req_ready_o ##1 (res_o.done && res_o.branched)))
      else $error("branch outcome malformed");
   AST_SKIP_CYC: assert property (res_o.done && res_o.skipped |-> res_o.cycles inside {2'h2, 2'h3})
      else $error("skip cycle count wrong");
   AST_SKIP3: assert property (res_o.done && res_o.cycles == 2'h3
      |-> res_o.skipped && !$past(req_ready_o, 1) && !$past(req_ready_o, 2))
      else $error("three cycle result malformed");
   AST_LOAD: assert property (acc && is_ld |=> mem_rd_o && !req_ready_o
      ##1 !mem_rd_o && res_o.done && res_o.cycles == 2'h2 && pc_o == seq_reg)
      else $error("load sequence wrong");
   AST_CMP: assert property (acc && is_cmp |=> res_o.done && req_ready_o && res_o.cycles == 2'h1
      && status_o[CSB_FLAG_S] == $past(status_o[CSB_FLAG_S]))
      else $error("compare not single cycle");
   AST_BUSY_PC: assert property (!req_ready_o |=> $stable(pc_o))
      else $error("pc moved while busy");
   COV_BR: cover property (res_o.done && res_o.branched);
   COV_SKIP3: cover property (res_o.done && res_o.cycles == 2'h3);
   COV_LOAD: cover property (mem_rd_o);
endmodule : csb_exec_sva
bind csb_exec csb_exec_sva u_csb_exec_sva (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
   .req_i(req_i), .req_ready_o(req_ready_o), .status_o(status_o), .pc_o(pc_o), .mem_rd_o(mem_rd_o), .res_o(res_o));
`default_nettype wire

// ---- verif/compare_skip_branch_decode_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module compare_skip_branch_decode_test;
   import csb_pkg::*;
   logic mclk, arst_n, req_valid, wr_en, sr_en, ready, mem_rd;
   logic [4:0] wr_addr, rd_addr;
   logic [7:0] wr_data, rd_data, sr_data, status, mem_rdata;
   logic [15:0] pc, mem_addr;
   csb_req_s req;
   csb_res_s res;
   int fails, tests_run, rd_pulses;
   csb_exec u_csb_exec (.mclk_i(mclk), .arst_n_i(arst_n), .req_valid_i(req_valid), .req_i(req),
      .req_ready_o(ready), .reg_wr_en_i(wr_en), .reg_wr_addr_i(wr_addr), .reg_wr_data_i(wr_data),
      .reg_rd_addr_i(rd_addr), .reg_rd_data_o(rd_data), .status_register_wr_en_i(sr_en), .status_register_wr_data_i(sr_data),
      .status_o(status), .pc_o(pc), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata),
      .res_o(res));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic step();
      @(posedge mclk);
      #5;
   endtask : step
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      step();
      wr_en = 1'b0;
      // let an edge pass so a following write never re-raises the strobe in the same time step
      step();
   endtask : wr_reg
   task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
      rd_addr = a;
      step();
      d = rd_data;
   endtask : rd_reg
   task automatic wr_status_register(input logic [7:0] d);
      sr_en = 1'b1;
      sr_data = d;
      step();
      sr_en = 1'b0;
   endtask : wr_status_register
   // waits are bounded; a hang ends the run as a mismatch
   task automatic issue(input csb_req_s r, output int n);
      int w;
      w = 0;
      while (ready !== 1'b1 && w < 8) begin
         step();
         w++;
      end
      req = r;
      req_valid = 1'b1;
      rd_pulses = 0;
      step();
      req_valid = 1'b0;
      n = 1;
      if (mem_rd === 1'b1) rd_pulses++;
      while (res.done !== 1'b1 && n < 6) begin
         step();
         n++;
         if (mem_rd === 1'b1) rd_pulses++;
      end
      if (res.done !== 1'b1 || w >= 8) begin
         fails++;
         $display("BAD done expected 1 seen %b", res.done);
         test_done();
      end
   endtask : issue
   function automatic logic br_cond(input csb_op_e op, input logic [7:0] s, input logic [2:0] b);
      case (op)
         branch_flag_set: return s[b];
         branch_flag_clear: return !s[b];
         branch_equal: return s[1];
         branch_not_equal: return !s[1];
         branch_carry_set, branch_lower: return s[0];
         branch_carry_clear, branch_same_or_higher: return !s[0];
         branch_minus: return s[2];
         branch_plus: return !s[2];
         branch_signed_ge: return !(s[2] ^ s[3]);
         branch_signed_less: return s[2] ^ s[3];
         branch_halfcarry_set: return s[5];
         branch_halfcarry_clear: return !s[5];
         branch_bitstore_set: return s[6];
         branch_bitstore_clear: return !s[6];
         branch_overflow_set: return s[3];
         branch_overflow_clear: return !s[3];
         branch_irq_enabled: return s[7];
         default: return !s[7];
      endcase
   endfunction : br_cond
   function automatic logic [7:0] cmp_flags(input logic [7:0] d, input logic [7:0] r, input logic ci,
      input logic [7:0] pre, input logic zk);
      logic [7:0] q;
      logic [7:0] b;
      logic [7:0] f;
      q = d - r - {7'h00, ci};
      b = (~d & r) | (r & q) | (q & ~d);
      f = pre;
      f[0] = b[7];
      f[5] = b[3];
      f[2] = q[7];
      f[3] = (d[7] & ~r[7] & ~q[7]) | (~d[7] & r[7] & q[7]);
      f[1] = (q == 8'h00) && (zk ? pre[1] : 1'b1);
      return f;
   endfunction : cmp_flags
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      logic [7:0] d;
      step();
      chk("ready", 16'h1, {15'h0, ready});
      chk("pc", 16'h0, pc);
      chk("status", 16'h0, {8'h0, status});
      rd_reg(5'h05, d);
      chk("reg", 16'h0, {8'h0, d});
      $display("test reset done");
   endtask : t_reset
   task automatic t_branch();
      logic [7:0] st [4] = '{8'h00, 8'hff, 8'h0c, 8'h04};
      csb_req_s r;
      logic [15:0] p;
      logic tk;
      int n;
      for (int i = 8; i <= 27; i++) begin
         for (int j = 0; j < 4; j++) begin
            r = '0;
            r.op = csb_op_e'(i);
            r.bit_sel = 3'(i + j);
            r.offset = j[0] ? 7'h40 : 7'h05;
            wr_status_register(st[j]);
            p = pc;
            tk = br_cond(r.op, st[j], r.bit_sel);
            issue(r, n);
            chk("branched", {15'h0, tk}, {15'h0, res.branched});
            chk("br_cycles", tk ? 16'h2 : 16'h1, 16'(n));
            chk("br_res_cycles", tk ? 16'h2 : 16'h1, {14'h0, res.cycles});
            chk("br_pc", p + 16'h1 + (tk ? {{9{r.offset[6]}}, r.offset} : 16'h0), pc);
         end
      end
      $display("test branch done");
   endtask : t_branch
   task automatic t_compare();
      logic [7:0] dv [5] = '{8'h10, 8'h05, 8'h80, 8'h18, 8'h00};
      logic [7:0] rv [5] = '{8'h10, 8'h80, 8'h01, 8'h09, 8'h01};
      csb_req_s r;
      logic [7:0] pre;
      logic [7:0] d;
      int n;
      for (int k = 0; k < 5; k++) begin
         for (int o = 1; o <= 3; o++) begin
            pre = (k + o) % 2 ? 8'h13 : 8'h00;
            wr_reg(5'h01, dv[k]);
            wr_reg(5'h02, rv[k]);
            wr_status_register(pre);
            r = '0;
            r.op = csb_op_e'(o);
            r.rd = 5'h01;
            r.rr = 5'h02;
            r.imm = rv[k];
            issue(r, n);
            chk("cmp_cycles", 16'h1, 16'(n));
            chk("cmp_flags", {8'h0, cmp_flags(dv[k], rv[k], o == 2 && pre[0], pre, o == 2)}, {8'h0, status});
            rd_reg(5'h01, d);
            chk("cmp_rd", {8'h0, dv[k]}, {8'h0, d});
         end
      end
      $display("test compare done");
   endtask : t_compare
   task automatic t_skip();
      csb_req_s r;
      logic [15:0] p;
      logic sk;
      int n;
      for (int i = 3; i < 8; i++) begin
         for (int v = 0; v < 4; v++) begin
            wr_reg(5'h03, 8'h5a);
            wr_reg(5'h04, v[0] ? 8'h5a : 8'h5b);
            r = '0;
            r.op = csb_op_e'(i == 3 ? 0 : i);
            r.rd = 5'h03;
            r.rr = i == 3 ? 5'h04 : 5'h03;
            r.bit_sel = v[0] ? 3'h3 : 3'h2;
            r.io_val = 8'h5a;
            r.next_two_word = v[1];
            sk = (i == 4 || i == 6) ? !v[0] : v[0];
            p = pc;
            issue(r, n);
            chk("skipped", {15'h0, sk}, {15'h0, res.skipped});
            chk("sk_cycles", sk ? (v[1] ? 16'h3 : 16'h2) : 16'h1, 16'(n));
            chk("sk_res_cycles", sk ? (v[1] ? 16'h3 : 16'h2) : 16'h1, {14'h0, res.cycles});
            chk("sk_pc", p + (sk ? (v[1] ? 16'h3 : 16'h2) : 16'h1), pc);
         end
      end
      $display("test skip done");
   endtask : t_skip
   task automatic t_load();
      csb_req_s r;
      logic [7:0] d;
      logic [15:0] x;
      int n;
      wr_reg(5'h1a, 8'hfe);
      wr_reg(5'h1b, 8'h12);
      x = 16'h12fe;
      for (int k = 0; k < 3; k++) begin
         r = '0;
         r.op = k == 1 ? load_indirect : load_indirect_post_inc;
         r.rd = 5'(5 + k);
         mem_rdata = 8'ha5 + 8'(k);
         issue(r, n);
         mem_rdata = ~mem_rdata;
         chk("ld_cycles", 16'h2, 16'(n));
         chk("ld_rd_pulse", 16'h1, 16'(rd_pulses));
         chk("ld_addr", x, mem_addr);
         if (k != 1) x = x + 16'h1;
         rd_reg(r.rd, d);
         chk("ld_data", 16'h00a5 + 16'(k), {8'h0, d});
         rd_reg(5'h1a, d);
         chk("ptr_lo", {8'h0, x[7:0]}, {8'h0, d});
         rd_reg(5'h1b, d);
         chk("ptr_hi", {8'h0, x[15:8]}, {8'h0, d});
      end
      $display("test load done");
   endtask : t_load
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   initial begin
      fails = 0;
      tests_run = 0;
      rd_pulses = 0;
      arst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      wr_en = 1'b0;
      wr_addr = 5'h00;
      wr_data = 8'h00;
      rd_addr = 5'h00;
      sr_en = 1'b0;
      sr_data = 8'h00;
      mem_rdata = 8'h00;
      repeat (6) @(posedge mclk);
      #5;
      arst_n = 1'b1;
      t_reset();
      t_branch();
      t_compare();
      t_skip();
      t_load();
      test_done();
   end
endmodule : compare_skip_branch_decode_test
`default_nettype wire
